// File: logic/ldo_control_register_bank.sv
// control and status register bank for three linear regulators
`timescale 1ns/1ps
`default_nettype none
module ldo_control_register_bank
  import ldo_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] i_address,
  input wire logic [7:0] i_write_data,
  input wire logic i_master_enable_n,
  input wire logic i_power_hold,
  input wire logic [2:0] i_above_rise,
  input wire logic [2:0] i_above_fall,
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  output logic [5:0] o_ldo_a_voltage_code,
  output logic o_ldo_a_range_select,
  output logic [4:0] o_ldo_b_voltage_code,
  output logic [4:0] o_ldo_c_voltage_code,
  output logic [2:0] o_ldo_enable,
  output logic [2:0] o_ldo_discharge
);

  // ****************************************
  // register state
  // ****************************************
  logic [5:0] ldo_a_voltage_code;
  logic ldo_a_range_select;
  logic [4:0] ldo_b_voltage_code;
  logic [4:0] ldo_c_voltage_code;
  logic ldo_b_enable;
  logic ldo_c_enable;
  logic [2:0] discharge_enable;
  logic exact_40;
  logic exact_43;
  logic [7:0] read_data;
  logic read_valid;

  logic [5:0] next_ldo_a_voltage_code;
  logic next_ldo_a_range_select;
  logic [4:0] next_ldo_b_voltage_code;
  logic [4:0] next_ldo_c_voltage_code;
  logic next_ldo_b_enable;
  logic next_ldo_c_enable;
  logic [2:0] next_discharge_enable;
  logic next_exact_40;
  logic next_exact_43;
  logic [7:0] next_read_data;
  logic next_read_valid;

  logic master_on;
  logic [2:0] enable_request;
  logic [2:0] power_good;
  logic [2:0] enable_state;
  logic [2:0] discharge_state;

  // master or hold turns first on
  assign master_on = !i_master_enable_n || i_power_hold;
  // others gated by their own bits
  assign enable_request = {master_on && ldo_c_enable, master_on && ldo_b_enable, master_on};

  // ****************************************
  // write path
  // ****************************************
  always_comb begin
    next_ldo_a_voltage_code = ldo_a_voltage_code;
    next_ldo_a_range_select = ldo_a_range_select;
    next_ldo_b_voltage_code = ldo_b_voltage_code;
    next_ldo_c_voltage_code = ldo_c_voltage_code;
    next_ldo_b_enable = ldo_b_enable;
    next_ldo_c_enable = ldo_c_enable;
    next_discharge_enable = discharge_enable;
    next_exact_40 = exact_40;
    next_exact_43 = exact_43;
    if (i_write) begin
      case (i_address)
        ADDR_LDO_A_VOLTAGE_SELECT: begin
          next_ldo_a_voltage_code = i_write_data[A_CODE_MSB:0];
          next_ldo_a_range_select = i_write_data[A_RANGE_BIT];
        end
        ADDR_LDO_RESERVED_CONTROL: begin
          // stored as written; host keeps default
          next_exact_40 = i_write_data[R40_EXACT_BIT];
        end
        ADDR_LDO_B_ENABLE_VOLTAGE: begin
          next_ldo_b_voltage_code = i_write_data[BC_CODE_MSB:0];
          next_ldo_b_enable = i_write_data[BC_ENABLE_BIT];
        end
        ADDR_LDO_C_ENABLE_VOLTAGE: begin
          next_ldo_c_voltage_code = i_write_data[BC_CODE_MSB:0];
          next_ldo_c_enable = i_write_data[BC_ENABLE_BIT];
        end
        ADDR_LDO_DISCHARGE_AND_GOOD: begin
          next_discharge_enable = i_write_data[DISCHARGE_A_BIT+2:DISCHARGE_A_BIT];
          next_exact_43 = i_write_data[R43_EXACT_BIT];
        end
        default: begin
          next_exact_40 = exact_40;
        end
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    next_read_valid = i_read;
    next_read_data = read_data;
    if (i_read) begin
      case (i_address)
        ADDR_LDO_A_VOLTAGE_SELECT:
          next_read_data = {1'b0, ldo_a_range_select, ldo_a_voltage_code};
        ADDR_LDO_RESERVED_CONTROL:
          next_read_data = {2'b00, exact_40, 5'h00};
        ADDR_LDO_B_ENABLE_VOLTAGE:
          next_read_data = {2'b00, ldo_b_enable, ldo_b_voltage_code};
        ADDR_LDO_C_ENABLE_VOLTAGE:
          next_read_data = {2'b00, ldo_c_enable, ldo_c_voltage_code};
        ADDR_LDO_DISCHARGE_AND_GOOD:
          // power good flags in top bits
          next_read_data = {power_good, discharge_enable, exact_43, 1'b0};
        default:
          next_read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ldo_a_voltage_code <= RST_A_CODE;
      ldo_a_range_select <= RST_A_RANGE;
      ldo_b_voltage_code <= RST_BC_CODE;
      ldo_c_voltage_code <= RST_BC_CODE;
      ldo_b_enable <= RST_BC_ENABLE;
      ldo_c_enable <= RST_BC_ENABLE;
      discharge_enable <= RST_DISCHARGE;
      exact_40 <= RST_EXACT;
      exact_43 <= RST_EXACT;
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      ldo_a_voltage_code <= next_ldo_a_voltage_code;
      ldo_a_range_select <= next_ldo_a_range_select;
      ldo_b_voltage_code <= next_ldo_b_voltage_code;
      ldo_c_voltage_code <= next_ldo_c_voltage_code;
      ldo_b_enable <= next_ldo_b_enable;
      ldo_c_enable <= next_ldo_c_enable;
      discharge_enable <= next_discharge_enable;
      exact_40 <= next_exact_40;
      exact_43 <= next_exact_43;
      read_data <= next_read_data;
      read_valid <= next_read_valid;
    end
  end

  // ****************************************
  // per-regulator switches and status
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ldo
      ldo_switch_control u_switch (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_enable_request(enable_request[g]),
        .i_discharge_enable(discharge_enable[g]),
        .o_enable(enable_state[g]),
        .o_discharge(discharge_state[g])
      );
      ldo_good_filter u_good (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_enabled(enable_state[g]),
        .i_above_rise(i_above_rise[g]),
        .i_above_fall(i_above_fall[g]),
        .o_good(power_good[g])
      );
    end
  endgenerate

  assign o_read_data = read_data;
  assign o_read_valid = read_valid;
  assign o_ldo_a_voltage_code = ldo_a_voltage_code;
  assign o_ldo_a_range_select = ldo_a_range_select;
  assign o_ldo_b_voltage_code = ldo_b_voltage_code;
  assign o_ldo_c_voltage_code = ldo_c_voltage_code;
  assign o_ldo_enable = enable_state;
  assign o_ldo_discharge = discharge_state;

  // ****************************************
  // checks
  // ****************************************
  chk_a_code_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_A_VOLTAGE_SELECT
    |=> o_ldo_a_voltage_code == $past(i_write_data[5:0]))
    else $error("first code not stored");
  chk_a_range_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_A_VOLTAGE_SELECT
    |=> o_ldo_a_range_select == $past(i_write_data[6]))
    else $error("range not stored");
  chk_b_code_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_B_ENABLE_VOLTAGE
    |=> o_ldo_b_voltage_code == $past(i_write_data[4:0]))
    else $error("second code not stored");
  chk_b_enable_out: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_B_ENABLE_VOLTAGE && !i_write_data[5]
    |=> ##1 !o_ldo_enable[1])
    else $error("second stays on after clear");
  chk_c_code_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_C_ENABLE_VOLTAGE
    |=> o_ldo_c_voltage_code == $past(i_write_data[4:0]))
    else $error("third code not stored");
  chk_c_enable_out: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_C_ENABLE_VOLTAGE && !i_write_data[5]
    |=> ##1 !o_ldo_enable[2])
    else $error("third stays on after clear");
  chk_discharge_off: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_ldo_discharge != 3'h0 |-> (o_ldo_discharge & o_ldo_enable) == 3'h0)
    else $error("discharge while enabled");
  chk_good_needs_on: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_ldo_enable[0] |=> !power_good[0])
    else $error("good flag while off");
  chk_master_on: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (!i_master_enable_n || i_power_hold) |=> o_ldo_enable[0])
    else $error("first not enabled by master");
  chk_readonly_zero: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_read && i_address == ADDR_LDO_B_ENABLE_VOLTAGE |=> o_read_data[7:6] == 2'b00)
    else $error("read-only bits not zero");
  chk_discharge_write: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_DISCHARGE_AND_GOOD
    |=> discharge_enable == $past(i_write_data[4:2]))
    else $error("discharge enables not stored");
  chk_b_follows_bit: assert property (
    @(posedge i_clock) disable iff (i_reset)
    master_on && ldo_b_enable |=> o_ldo_enable[1])
    else $error("second not on with master and bit");
  chk_c_enable_on: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_write && i_address == ADDR_LDO_C_ENABLE_VOLTAGE && i_write_data[5]
    ##1 master_on |=> o_ldo_enable[2])
    else $error("third not on after set");
  chk_master_off: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_master_enable_n && !i_power_hold |=> !o_ldo_enable[0])
    else $error("first on without master");
  chk_discharge_on: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_master_enable_n && !i_power_hold && discharge_enable[0]
    |=> o_ldo_discharge[0])
    else $error("no discharge while off");
  chk_good_read: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_read && i_address == ADDR_LDO_DISCHARGE_AND_GOOD
    |=> o_read_data[7:5] == $past(power_good))
    else $error("power good flags misread");
  chk_good_holds: assert property (
    @(posedge i_clock) disable iff (i_reset)
    power_good[0] && o_ldo_enable[0] && i_above_fall[0] |=> power_good[0])
    else $error("good dropped above falling threshold");
  chk_good_drop: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !i_above_fall[1] |=> !power_good[1])
    else $error("good kept below falling threshold");
  chk_reserved_zero: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_read && i_address == ADDR_LDO_RESERVED_CONTROL
    |=> o_read_data[7:6] == 2'b00 && o_read_data[4:0] == 5'h00)
    else $error("reserved read-only bits not zero");
  chk_a_top_zero: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_read && i_address == ADDR_LDO_A_VOLTAGE_SELECT |=> !o_read_data[7])
    else $error("first register top bit not zero");
endmodule
`default_nettype wire

// File: include/ldo_pkg.sv
// constants for the linear regulator control register bank
package ldo_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_LDO_A_VOLTAGE_SELECT = 8'h03;
  localparam logic [7:0] ADDR_LDO_RESERVED_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_LDO_B_ENABLE_VOLTAGE = 8'h41;
  localparam logic [7:0] ADDR_LDO_C_ENABLE_VOLTAGE = 8'h42;
  localparam logic [7:0] ADDR_LDO_DISCHARGE_AND_GOOD = 8'h43;

  // ****************************************
  // field positions
  // ****************************************
  localparam int A_CODE_MSB = 5;
  localparam int A_RANGE_BIT = 6;
  localparam int BC_CODE_MSB = 4;
  localparam int BC_ENABLE_BIT = 5;
  localparam int R40_EXACT_BIT = 5;
  localparam int R43_EXACT_BIT = 1;
  localparam int DISCHARGE_A_BIT = 2;
  localparam int GOOD_A_BIT = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] RST_A_CODE = 6'h00;
  localparam logic RST_A_RANGE = 1'b0;
  localparam logic [4:0] RST_BC_CODE = 5'h00;
  localparam logic RST_BC_ENABLE = 1'b0;
  localparam logic [2:0] RST_DISCHARGE = 3'h0;
  localparam logic RST_EXACT = 1'b0;

  // ****************************************
  // power-good filtering: qualify count in cycles
  // ****************************************
  localparam logic [3:0] GOOD_QUALIFY_CYCLES = 4'h4;

endpackage

// File: logic/ldo_good_filter.sv
// per-regulator power-good qualification
`timescale 1ns/1ps
`default_nettype none
module ldo_good_filter
  import ldo_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enabled,
  input wire logic i_above_rise,
  input wire logic i_above_fall,
  output logic o_good
);
  logic good;
  logic [3:0] count;
  logic next_good;
  logic [3:0] next_count;

  // ****************************************
  // hysteresis
  // ****************************************
  always_comb begin
    next_good = good;
    next_count = count;
    // rise at 89 percent, fall 4 lower
    if (!i_enabled || !i_above_fall) begin
      next_good = 1'b0;
      next_count = 4'h0;
    end else if (!good && i_above_rise) begin
      // short glitches on the comparator are ignored
      if (count == GOOD_QUALIFY_CYCLES - 4'h1) begin
        next_good = 1'b1;
        next_count = 4'h0;
      end else begin
        next_count = count + 4'h1;
      end
    end else if (!good) begin
      next_count = 4'h0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      good <= 1'b0;
      count <= 4'h0;
    end else begin
      good <= next_good;
      count <= next_count;
    end
  end

  assign o_good = good;
endmodule
`default_nettype wire

// File: logic/ldo_switch_control.sv
// enable and discharge switch drive for one regulator
`timescale 1ns/1ps
`default_nettype none
module ldo_switch_control (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable_request,
  input wire logic i_discharge_enable,
  output logic o_enable,
  output logic o_discharge
);
  logic enable;
  logic discharge;
  logic next_enable;
  logic next_discharge;

  always_comb begin
    next_enable = i_enable_request;
    next_discharge = !i_enable_request && i_discharge_enable;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      enable <= 1'b0;
      discharge <= 1'b0;
    end else begin
      enable <= next_enable;
      discharge <= next_discharge;
    end
  end

  assign o_enable = enable;
  assign o_discharge = discharge;
endmodule
`default_nettype wire

// File: dv/ldo_host_model.sv
// host processor model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module ldo_host_model
  import ldo_pkg::*;
(
  input wire logic i_clock,
  input wire logic [7:0] i_read_data,
  input wire logic i_read_valid,
  output logic o_write,
  output logic o_read,
  output logic [7:0] o_address,
  output logic [7:0] o_write_data
);
  initial begin
    o_write = 1'b0;
    o_read = 1'b0;
    o_address = 8'h00;
    o_write_data = 8'h00;
  end
  // ****************************************
  // bus cycles
  // ****************************************
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_LDO_RESERVED_CONTROL) v[R40_EXACT_BIT] = RST_EXACT;
    if (a == ADDR_LDO_DISCHARGE_AND_GOOD) v[R43_EXACT_BIT] = RST_EXACT;
    @(posedge i_clock);
    o_write <= 1'b1;
    o_address <= a;
    o_write_data <= v;
    @(posedge i_clock);
    o_write <= 1'b0;
    // idle lines show the inverse so stale values never pass
    o_address <= ~a;
    o_write_data <= ~v;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_clock);
    o_read <= 1'b1;
    o_address <= a;
    @(posedge i_clock);
    o_read <= 1'b0;
    o_address <= ~a;
    #1;
    d = i_read_data;
    ok = i_read_valid;
  endtask
endmodule
`default_nettype wire

// File: dv/ldo_control_register_bank_bench.sv
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module ldo_control_register_bank_bench
  import ldo_pkg::*;
;
  logic i_clock, i_reset, i_master_enable_n, i_power_hold;
  logic [2:0] i_above_rise, i_above_fall;
  logic w, r, ok, ok_v;
  logic [7:0] addr, wdata, rdata, d, got;
  logic [5:0] a_code;
  logic a_range;
  logic [4:0] b_code, c_code;
  logic [2:0] en, dis, exp_en;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'hfd2787df;
  int exp_reg[5];
  logic [7:0] addr_list[5] = '{8'h03, 8'h40, 8'h41, 8'h42, 8'h43};
  logic [7:0] wmask[5] = '{8'h7F, 8'h00, 8'h3F, 8'h3F, 8'h1C};

  ldo_control_register_bank uut (.i_clock(i_clock), .i_reset(i_reset), .i_write(w),
    .i_read(r), .i_address(addr), .i_write_data(wdata),
    .i_master_enable_n(i_master_enable_n), .i_power_hold(i_power_hold),
    .i_above_rise(i_above_rise), .i_above_fall(i_above_fall), .o_read_data(rdata),
    .o_read_valid(ok_v), .o_ldo_a_voltage_code(a_code), .o_ldo_a_range_select(a_range),
    .o_ldo_b_voltage_code(b_code), .o_ldo_c_voltage_code(c_code), .o_ldo_enable(en),
    .o_ldo_discharge(dis));
  ldo_host_model host (.i_clock(i_clock), .i_read_data(rdata), .i_read_valid(ok_v),
    .o_write(w), .o_read(r), .o_address(addr), .o_write_data(wdata));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    checks++;
    if (seen !== expected) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic read_check(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, got, ok);
    check({7'h00, ok}, 8'h01);
    check(got, e);
  endtask
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_reset = 1'b1;
    i_master_enable_n = 1'b1;
    i_power_hold = 1'b0;
    i_above_rise = 3'h0;
    i_above_fall = 3'h0;
    for (int i = 0; i < 5; i++) exp_reg[i] = 0;
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int i = 0; i < 5; i++) read_check(addr_list[i], 8'h00);
    read_check(8'h44, 8'h00);
    repeat (6) begin
      for (int i = 0; i < 5; i++) begin
        d = $random(seed);
        host.write_reg(addr_list[i], d);
        exp_reg[i] = d & wmask[i];
        #1;
        if (i == 0) check({1'b0, a_range, a_code}, d & 8'h7F);
        if (i == 2) check({3'h0, b_code}, d & 8'h1F);
        if (i == 3) check({3'h0, c_code}, d & 8'h1F);
        read_check(addr_list[i], exp_reg[i][7:0]);
      end
      host.write_reg(8'h44, $random(seed));
      read_check(8'h44, 8'h00);
    end
    // enable and discharge per master condition
    host.write_reg(ADDR_LDO_DISCHARGE_AND_GOOD, 8'h1C);
    host.write_reg(ADDR_LDO_B_ENABLE_VOLTAGE, 8'h25);
    host.write_reg(ADDR_LDO_C_ENABLE_VOLTAGE, 8'h0A);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      i_master_enable_n <= k[0];
      i_power_hold <= k[1];
      repeat (3) @(posedge i_clock);
      #1;
      exp_en[0] = ~k[0] | k[1];
      exp_en[1] = exp_en[0];
      exp_en[2] = 1'b0;
      check({5'h00, en}, {5'h00, exp_en});
      check({5'h00, dis}, {5'h00, ~exp_en});
    end
    @(posedge i_clock);
    i_master_enable_n <= 1'b0;
    host.write_reg(ADDR_LDO_C_ENABLE_VOLTAGE, 8'h20);
    #1;
    check({5'h00, en}, 8'h03);
    @(posedge i_clock);
    #1;
    check({5'h00, en}, 8'h07);
    @(posedge i_clock);
    i_above_rise <= 3'h7;
    i_above_fall <= 3'h7;
    repeat (10) @(posedge i_clock);
    read_check(ADDR_LDO_DISCHARGE_AND_GOOD, 8'hFC);
    @(posedge i_clock);
    i_above_rise <= 3'h0;
    repeat (4) @(posedge i_clock);
    read_check(ADDR_LDO_DISCHARGE_AND_GOOD, 8'hFC);
    @(posedge i_clock);
    i_above_fall <= 3'h5;
    repeat (3) @(posedge i_clock);
    read_check(ADDR_LDO_DISCHARGE_AND_GOOD, 8'hBC);
    host.write_reg(ADDR_LDO_C_ENABLE_VOLTAGE, 8'h00);
    repeat (3) @(posedge i_clock);
    read_check(ADDR_LDO_DISCHARGE_AND_GOOD, 8'h3C);
    check({5'h00, dis}, 8'h04);
    conclude();
  end
endmodule
`default_nettype wire
